// file: pkg/counter_compare_pkg.sv
package counter_compare_pkg;

  // ****************************************************************
  // Word addresses in the page-frame memory
  // ****************************************************************
  localparam logic [6:0] ADDR_MASTER_MODE = 7'h04;
  localparam logic [6:0] ADDR_IRQ_ENABLE = 7'h07;
  localparam logic [6:0] ADDR_EDGE_POL = 7'h08;
  localparam logic [6:0] ADDR_CMP1 = 7'h13;
  localparam logic [6:0] ADDR_CMP2 = 7'h21;
  localparam logic [6:0] ADDR_CMP3 = 7'h2f;
  localparam logic [6:0] ADDR_CMP4 = 7'h3d;
  localparam logic [6:0] ADDR_CMP5 = 7'h4b;
  localparam logic [6:0] ADDR_CH6_MODE = 7'h56;
  localparam logic [6:0] ADDR_CMP6_HI = 7'h5b;
  localparam logic [6:0] ADDR_CMP6_LO = 7'h5c;
  localparam logic [6:0] ADDR_CH7_MODE = 7'h67;
  localparam logic [6:0] ADDR_CMP7_HI = 7'h6c;
  localparam logic [6:0] ADDR_CMP7_LO = 7'h6d;
  localparam logic [6:0] ADDR_EVENT_INFO = 7'h70;
  localparam logic [6:0] ADDR_EDGE_INFO = 7'h71;
  localparam logic [6:0] ADDR_ERROR_INFO = 7'h72;
  localparam logic [6:0] ADDR_CH6_COUNT_HI = 7'h73;
  localparam logic [6:0] ADDR_CH6_COUNT_LO = 7'h74;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [15:0] MMR_CMP_MASK = 16'h700c;
  localparam int IEN_ERR_BIT = 0;
  localparam int IEN_CNT_BIT = 8;
  localparam int IEN_OUT_LSB = 9;
  localparam int POL_GATE_LSB = 1;
  localparam int POL_OUT_LSB = 9;
  localparam int MODE_CMP_BIT = 3;
  localparam int MODE_EDGE_LSB = 4;
  localparam int MODE_RST_BIT = 7;
  localparam logic [2:0] EDGE_SIMPLE = 3'h1;
  localparam int HI_SIGN_BIT = 15;
  localparam int HI_UPPER_MSB = 7;
  localparam int CH6_IDX = 5;
  localparam int CH7_IDX = 6;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic [4:0] gate;
    logic in_a;
    logic rst;
  } pins_t;

endpackage : counter_compare_pkg

// file: hdl/counter_compare_interrupt.sv
// How it works
// - Enabled comparator match on equality raises interrupt
// - Counters 6/7 compare: high word sign+23..16
// - Mode bit 3 switches counter 6/7 comparator
// - Comparators 1-5 need master bits 2,3,12-14
// - Enable bit 0 gates error group interrupt
// - Enable bit 8 gates counter event interrupt
// - Enable bits 9-15 gate counter outputs 1-7
// - Polarity bits 1-5 pick gate edge
// - Polarity bits 9-13 pick output edge
// - Counter 6 simple mode: A up/down
// - Counter 6 reset input ignored unless bit 7
module counter_compare_interrupt #(
  parameter int LONG_W = 25
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire counter_compare_pkg::host_req_t i_host,
  input wire counter_compare_pkg::pins_t i_pins,
  input wire logic [4:0][15:0] i_count_value,
  input wire logic [LONG_W-1:0] i_ch7_value,
  input wire logic [4:0] i_count_out,
  input wire logic i_ch7_out,
  input wire logic [7:0] i_error_evt,
  output logic [15:0] o_rd_data,
  output logic o_irq,
  output logic o_err_irq,
  output logic [6:0] o_counter_out,
  output logic [LONG_W-1:0] o_ch6_value
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (LONG_W != 25) begin : g_bad_width
    $error("LONG_W must be 25: sign plus 24 bits");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] mmr;
    logic [15:0] ien;
    logic [15:0] pol;
    logic [15:0] ch6_mode;
    logic [15:0] ch7_mode;
    logic [4:0][15:0] cmp;
    logic [15:0] cmp6_hi;
    logic [15:0] cmp6_lo;
    logic [15:0] cmp7_hi;
    logic [15:0] cmp7_lo;
    logic [LONG_W-1:0] ch6_count;
    counter_compare_pkg::pins_t sync1;
    counter_compare_pkg::pins_t sync2;
    logic [4:0] gate_q;
    logic [4:0] out_q;
    logic a_q;
    logic rst_q;
    logic [6:0] match_q;
    logic [15:0] event_info;
    logic [15:0] edge_info;
    logic [7:0] err_info;
    logic [15:0] rd_data;
    logic irq;
    logic err_irq;
    logic [6:0] cnt_out;
  } state_t;

  localparam state_t STATE_RESET = '0;

  state_t st_reg;
  state_t st_next;

  // ****************************************************************
  // Comparators
  // ****************************************************************
  logic [6:0] match_now;
  logic [6:0] cmp_active;
  logic [LONG_W-1:0] cmp6_full;
  logic [LONG_W-1:0] cmp7_full;
  logic cmp15_on;

  // Sign and upper byte from high word, low 16 bits from low word
  assign cmp6_full = {st_reg.cmp6_hi[counter_compare_pkg::HI_SIGN_BIT],
                      st_reg.cmp6_hi[counter_compare_pkg::HI_UPPER_MSB:0],
                      st_reg.cmp6_lo};
  assign cmp7_full = {st_reg.cmp7_hi[counter_compare_pkg::HI_SIGN_BIT],
                      st_reg.cmp7_hi[counter_compare_pkg::HI_UPPER_MSB:0],
                      st_reg.cmp7_lo};

  // Comparators 1-5 share the master mode enable pattern
  assign cmp15_on = (st_reg.mmr & counter_compare_pkg::MMR_CMP_MASK)
                    == counter_compare_pkg::MMR_CMP_MASK;

  // Equality per counter and activity per counter
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      match_now[i] = i_count_value[i] == st_reg.cmp[i];
      cmp_active[i] = cmp15_on;
    end
    match_now[counter_compare_pkg::CH6_IDX] = st_reg.ch6_count == cmp6_full;
    match_now[counter_compare_pkg::CH7_IDX] = i_ch7_value == cmp7_full;
    cmp_active[counter_compare_pkg::CH6_IDX] =
      st_reg.ch6_mode[counter_compare_pkg::MODE_CMP_BIT];
    cmp_active[counter_compare_pkg::CH7_IDX] =
      st_reg.ch7_mode[counter_compare_pkg::MODE_CMP_BIT];
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic [6:0] cmp_evt;
    logic [4:0] gate_evt;
    logic [4:0] out_evt;
    logic [6:0] raw_out;
    logic a_rise;
    logic a_fall;
    logic rst_rise;
    logic rd_event;
    logic rd_edge;
    logic rd_err;
    cmp_evt = '0;
    gate_evt = '0;
    out_evt = '0;
    raw_out = '0;
    a_rise = 1'b0;
    a_fall = 1'b0;
    rst_rise = 1'b0;
    rd_event = 1'b0;
    rd_edge = 1'b0;
    rd_err = 1'b0;
    st_next = st_reg;

    // Two-stage synchronisers for pins
    st_next.sync1 = i_pins;
    st_next.sync2 = st_reg.sync1;
    st_next.gate_q = st_reg.sync2.gate;
    st_next.a_q = st_reg.sync2.in_a;
    st_next.rst_q = st_reg.sync2.rst;
    st_next.out_q = i_count_out;
    st_next.match_q = match_now;

    // Counter 6 edge evaluation and reset input
    a_rise = st_reg.sync2.in_a && !st_reg.a_q;
    a_fall = !st_reg.sync2.in_a && st_reg.a_q;
    rst_rise = st_reg.sync2.rst && !st_reg.rst_q;
    if (rst_rise && st_reg.ch6_mode[counter_compare_pkg::MODE_RST_BIT]) begin
      st_next.ch6_count = '0;
    end else if (st_reg.ch6_mode[counter_compare_pkg::MODE_EDGE_LSB +: 3]
                 == counter_compare_pkg::EDGE_SIMPLE) begin
      if (a_rise) begin
        st_next.ch6_count = st_reg.ch6_count + 1'b1;
      end else if (a_fall) begin
        st_next.ch6_count = st_reg.ch6_count - 1'b1;
      end
    end

    // Events: new equality, gate and output edges of chosen polarity
    for (int i = 0; i < 7; i++) begin
      cmp_evt[i] = st_reg.ien[counter_compare_pkg::IEN_CNT_BIT]
                   && cmp_active[i] && match_now[i]
                   && !st_reg.match_q[i];
    end
    for (int i = 0; i < 5; i++) begin
      gate_evt[i] = st_reg.ien[counter_compare_pkg::IEN_CNT_BIT] &&
        (st_reg.pol[counter_compare_pkg::POL_GATE_LSB + i]
         ? (st_reg.sync2.gate[i] && !st_reg.gate_q[i])
         : (!st_reg.sync2.gate[i] && st_reg.gate_q[i]));
      out_evt[i] = st_reg.ien[counter_compare_pkg::IEN_CNT_BIT] &&
        (st_reg.pol[counter_compare_pkg::POL_OUT_LSB + i]
         ? (i_count_out[i] && !st_reg.out_q[i])
         : (!i_count_out[i] && st_reg.out_q[i]));
    end

    // Host read: data and clear-on-read of the info words
    if (i_host.rd) begin
      unique case (i_host.addr)
        counter_compare_pkg::ADDR_MASTER_MODE: st_next.rd_data = st_reg.mmr;
        counter_compare_pkg::ADDR_IRQ_ENABLE: st_next.rd_data = st_reg.ien;
        counter_compare_pkg::ADDR_EDGE_POL: st_next.rd_data = st_reg.pol;
        counter_compare_pkg::ADDR_CMP1: st_next.rd_data = st_reg.cmp[0];
        counter_compare_pkg::ADDR_CMP2: st_next.rd_data = st_reg.cmp[1];
        counter_compare_pkg::ADDR_CMP3: st_next.rd_data = st_reg.cmp[2];
        counter_compare_pkg::ADDR_CMP4: st_next.rd_data = st_reg.cmp[3];
        counter_compare_pkg::ADDR_CMP5: st_next.rd_data = st_reg.cmp[4];
        counter_compare_pkg::ADDR_CH6_MODE: st_next.rd_data = st_reg.ch6_mode;
        counter_compare_pkg::ADDR_CMP6_HI: st_next.rd_data = st_reg.cmp6_hi;
        counter_compare_pkg::ADDR_CMP6_LO: st_next.rd_data = st_reg.cmp6_lo;
        counter_compare_pkg::ADDR_CH7_MODE: st_next.rd_data = st_reg.ch7_mode;
        counter_compare_pkg::ADDR_CMP7_HI: st_next.rd_data = st_reg.cmp7_hi;
        counter_compare_pkg::ADDR_CMP7_LO: st_next.rd_data = st_reg.cmp7_lo;
        counter_compare_pkg::ADDR_EVENT_INFO: begin
          st_next.rd_data = st_reg.event_info;
          rd_event = 1'b1;
        end
        counter_compare_pkg::ADDR_EDGE_INFO: begin
          st_next.rd_data = st_reg.edge_info;
          rd_edge = 1'b1;
        end
        counter_compare_pkg::ADDR_ERROR_INFO: begin
          st_next.rd_data = {8'h00, st_reg.err_info};
          rd_err = 1'b1;
        end
        counter_compare_pkg::ADDR_CH6_COUNT_HI:
          st_next.rd_data = {st_reg.ch6_count[LONG_W-1], 7'h00,
                             st_reg.ch6_count[LONG_W-2:16]};
        counter_compare_pkg::ADDR_CH6_COUNT_LO:
          st_next.rd_data = st_reg.ch6_count[15:0];
        default: st_next.rd_data = counter_compare_pkg::REG_RESET;
      endcase
    end

    // Host write of configuration words
    if (i_host.wr) begin
      unique case (i_host.addr)
        counter_compare_pkg::ADDR_MASTER_MODE: st_next.mmr = i_host.wdata;
        counter_compare_pkg::ADDR_IRQ_ENABLE: st_next.ien = i_host.wdata;
        counter_compare_pkg::ADDR_EDGE_POL: st_next.pol = i_host.wdata;
        counter_compare_pkg::ADDR_CMP1: st_next.cmp[0] = i_host.wdata;
        counter_compare_pkg::ADDR_CMP2: st_next.cmp[1] = i_host.wdata;
        counter_compare_pkg::ADDR_CMP3: st_next.cmp[2] = i_host.wdata;
        counter_compare_pkg::ADDR_CMP4: st_next.cmp[3] = i_host.wdata;
        counter_compare_pkg::ADDR_CMP5: st_next.cmp[4] = i_host.wdata;
        counter_compare_pkg::ADDR_CH6_MODE: st_next.ch6_mode = i_host.wdata;
        counter_compare_pkg::ADDR_CMP6_HI: st_next.cmp6_hi = i_host.wdata;
        counter_compare_pkg::ADDR_CMP6_LO: st_next.cmp6_lo = i_host.wdata;
        counter_compare_pkg::ADDR_CH7_MODE: st_next.ch7_mode = i_host.wdata;
        counter_compare_pkg::ADDR_CMP7_HI: st_next.cmp7_hi = i_host.wdata;
        counter_compare_pkg::ADDR_CMP7_LO: st_next.cmp7_lo = i_host.wdata;
        default: ;
      endcase
    end

    // Sticky causes: new events win over the read clear
    st_next.event_info = (rd_event ? '0 : st_reg.event_info)
                         | {9'h000, cmp_evt};
    st_next.edge_info = (rd_edge ? '0 : st_reg.edge_info)
                        | {2'h0, out_evt, 3'h0, gate_evt, 1'b0};
    st_next.err_info = (rd_err ? '0 : st_reg.err_info) | i_error_evt;

    // Request lines held while any cause of an enabled group is latched
    st_next.irq = st_reg.ien[counter_compare_pkg::IEN_CNT_BIT]
      && (st_next.event_info != '0 || st_next.edge_info != '0);
    st_next.err_irq = st_reg.ien[counter_compare_pkg::IEN_ERR_BIT]
      && st_next.err_info != '0;

    // Counter outputs gated by their enable bits
    raw_out = {i_ch7_out, match_now[counter_compare_pkg::CH6_IDX]
               && cmp_active[counter_compare_pkg::CH6_IDX], i_count_out};
    st_next.cnt_out = raw_out
      & st_reg.ien[counter_compare_pkg::IEN_OUT_LSB +: 7];
  end

  // Single register stage
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flip-flops
  assign o_rd_data = st_reg.rd_data;
  assign o_irq = st_reg.irq;
  assign o_err_irq = st_reg.err_irq;
  assign o_counter_out = st_reg.cnt_out;
  assign o_ch6_value = st_reg.ch6_count;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  cmp_match_irq_a: assert property (
    (st_reg.ien[8] && cmp15_on && match_now[0] && !st_reg.match_q[0]
     && !(i_host.rd && i_host.addr == counter_compare_pkg::ADDR_EVENT_INFO))
    |=> st_reg.event_info[0] ##0 (o_irq || !st_reg.ien[8]))
    else $error("comparator 1 match not latched");
  ch6_split_a: assert property (
    (st_reg.ien[8] && st_reg.ch6_mode[3] && match_now[5]
     && !st_reg.match_q[5])
    |=> st_reg.event_info[5]
        && $past(st_reg.ch6_count[24]) == $past(st_reg.cmp6_hi[15]))
    else $error("counter 6 compare split wrong");
  ch6_cmp_off_a: assert property (
    (!st_reg.ch6_mode[3] && !st_reg.event_info[5]) |=> !st_reg.event_info[5])
    else $error("counter 6 comparator fired while off");
  master_gate_a: assert property (
    (!cmp15_on && !st_reg.event_info[0]) |=> !st_reg.event_info[0])
    else $error("comparator 1 fired without master bits");
  err_irq_a: assert property (
    (i_error_evt != '0 && st_reg.ien[0]) |=> o_err_irq)
    else $error("error interrupt missing");
  cnt_irq_en_a: assert property (
    $rose(o_irq) |-> $past(st_reg.ien[8]))
    else $error("counter interrupt without enable");
  out_enable_a: assert property (
    (!st_reg.ien[9] && !o_counter_out[0]) |=> !o_counter_out[0])
    else $error("output 1 driven while disabled");
  gate_edge_a: assert property (
    (st_reg.ien[8] && st_reg.pol[1] && st_reg.sync2.gate[0]
     && !st_reg.gate_q[0]) |=> st_reg.edge_info[1])
    else $error("gate 1 rising edge not latched");
  out_edge_a: assert property (
    (st_reg.ien[8] && st_reg.pol[9] && $rose(i_count_out[0]))
    |-> ##1 st_reg.edge_info[9])
    else $error("output 1 rising edge not latched");
  ch6_count_a: assert property (
    (st_reg.ch6_mode[6:4] == 3'h1 && !st_reg.ch6_mode[7]
     && st_reg.sync2.in_a && !st_reg.a_q)
    |=> st_reg.ch6_count == $past(st_reg.ch6_count) + 25'h0000001)
    else $error("counter 6 did not count up");
  ch6_rst_off_a: assert property (
    (!st_reg.ch6_mode[7] && st_reg.sync2.in_a == st_reg.a_q)
    |=> $stable(st_reg.ch6_count))
    else $error("counter 6 reset input not ignored");
  irq_hold_a: assert property (
    (o_irq && st_reg.ien[8] && !i_host.wr && !i_host.rd) [*2]
    |=> o_irq)
    else $error("interrupt dropped before read");
  cmp_hit_c: cover property (st_reg.event_info[0] && o_irq);
  ch6_hit_c: cover property (st_reg.event_info[5]);
  ack_read_c: cover property (
    o_irq && i_host.rd && i_host.addr == counter_compare_pkg::ADDR_EVENT_INFO
    ##1 !o_irq);
  gate_hit_c: cover property (st_reg.edge_info[1]);

endmodule : counter_compare_interrupt

// file: verif/host_model.sv
module host_model (
  input wire logic i_clk,
  input wire logic [15:0] i_rd_data,
  output counter_compare_pkg::host_req_t o_host
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus until the first access
  initial o_host = '0;

  // Fast write: data into the page frame, no control word
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(negedge i_clk);
    o_host = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge i_clk);
    o_host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // Fast read: word fetched one cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(negedge i_clk);
    o_host = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(negedge i_clk);
    d = i_rd_data;
    o_host = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'hffff};
  endtask : rd

  // Acknowledge: read event, edge and error information words
  task automatic ack(output logic [15:0] e, g, r);
    rd(counter_compare_pkg::ADDR_EVENT_INFO, e);
    rd(counter_compare_pkg::ADDR_EDGE_INFO, g);
    rd(counter_compare_pkg::ADDR_ERROR_INFO, r);
  endtask : ack
endmodule : host_model

// file: verif/counter_compare_interrupt_bench.sv
`define CHK(a, b) begin \
  tests_run++; \
  if ((a) !== (b)) begin \
    failures++; \
    $display("ERROR %0t value %h expected %h", $time, a, b); \
  end \
end

module counter_compare_interrupt_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk, arst_n, ch7_out, irq, err_irq;
  counter_compare_pkg::host_req_t host;
  counter_compare_pkg::pins_t pins;
  logic [4:0][15:0] cnt;
  logic [24:0] ch7, ch6_val;
  logic [4:0] cout;
  logic [7:0] err_evt;
  logic [15:0] rd_data;
  logic [6:0] cnt_out;
  int failures, tests_run;
  logic [6:0] regs [14] = '{7'h04, 7'h07, 7'h08, 7'h13, 7'h21, 7'h2f,
    7'h3d, 7'h4b, 7'h56, 7'h5b, 7'h5c, 7'h67, 7'h6c, 7'h6d};

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  counter_compare_interrupt #(.LONG_W(25)) i_counter_compare_interrupt (
    .i_clk(clk), .i_arst_n(arst_n), .i_host(host), .i_pins(pins),
    .i_count_value(cnt), .i_ch7_value(ch7), .i_count_out(cout),
    .i_ch7_out(ch7_out), .i_error_evt(err_evt), .o_rd_data(rd_data),
    .o_irq(irq), .o_err_irq(err_irq), .o_counter_out(cnt_out),
    .o_ch6_value(ch6_val)
  );

  host_model i_host_model (.i_clk(clk), .i_rd_data(rd_data), .o_host(host));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic test_done();
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  // Bounded wait for one of the interrupt lines
  task automatic wait_irq(input bit err);
    int n;
    n = 0;
    while ((err ? err_irq : irq) !== 1'b1 && n < 10) begin
      @(negedge clk);
      n++;
    end
    if ((err ? err_irq : irq) !== 1'b1) begin
      failures++;
      $display("ERROR %0t interrupt never came", $time);
      test_done();
    end
  endtask : wait_irq

  // Let synchronisers and registers settle
  task automatic idle();
    repeat (6) @(negedge clk);
  endtask : idle

  // Expected edge info word: gates 1-5 for i 0-4, outputs 1-5 for i 5-9
  function automatic logic [15:0] edge_word(input int i);
    return 16'h0002 << (i < 5 ? i : i + 3);
  endfunction : edge_word

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [15:0] d, v, e, g, r;
    logic [23:0] v24;
    logic sgn;
    int i;
    failures = 0;
    tests_run = 0;
    arst_n = 1'b0;
    pins = '0;
    cnt = '0;
    ch7 = '0;
    cout = '0;
    ch7_out = 1'b0;
    err_evt = '0;
    void'($urandom(64));
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    // Reset values, read-back and an unmapped word
    foreach (regs[k]) begin
      i_host_model.rd(regs[k], d);
      `CHK(d, counter_compare_pkg::REG_RESET)
      v = 16'($urandom);
      i_host_model.wr(regs[k], v);
      i_host_model.rd(regs[k], d);
      `CHK(d, v)
    end
    foreach (regs[k]) i_host_model.wr(regs[k], 16'h0000);
    i_host_model.rd(7'h7f, d);
    `CHK(d, 16'h0000)
    i_host_model.ack(e, g, r);
    // Comparators 1 to 5
    i_host_model.wr(counter_compare_pkg::ADDR_MASTER_MODE, 16'h700c);
    i_host_model.wr(counter_compare_pkg::ADDR_IRQ_ENABLE, 16'h0100);
    for (i = 0; i < 5; i++) begin
      v = 16'($urandom_range(1, 65535));
      i_host_model.wr(regs[3 + i], v);
      @(negedge clk); // Unequal state sampled before the match
      cnt[i] = v;
      wait_irq(1'b0);
      i_host_model.ack(e, g, r);
      `CHK(e, 16'(1 << i))
      `CHK(irq, 1'b0)
      cnt[i] = 16'h0000;
    end
    // One master bit missing, then the event group masked
    i = 2 + $urandom_range(0, 4);
    if (i > 3) i = i + 8;
    i_host_model.wr(7'h04, 16'h700c & ~(16'h0001 << i));
    cnt[4] = v;
    idle();
    `CHK(irq, 1'b0)
    cnt[4] = 16'h0000;
    i_host_model.wr(7'h04, 16'h700c);
    i_host_model.wr(7'h07, 16'h0000);
    cnt[4] = v;
    idle();
    i_host_model.rd(7'h70, e);
    `CHK(e, 16'h0000)
    cnt[4] = 16'h0000;
    // Counter 7 comparator, two-word value
    v24 = 24'($urandom_range(1, 16777215));
    sgn = 1'($urandom);
    i_host_model.wr(7'h07, 16'h0100);
    i_host_model.wr(7'h6c, {sgn, 7'h00, v24[23:16]});
    i_host_model.wr(7'h6d, v24[15:0]);
    ch7 = {sgn, v24};
    idle();
    `CHK(irq, 1'b0)
    ch7 = '0;
    i_host_model.wr(7'h67, 16'h0008);
    ch7 = {sgn, v24};
    wait_irq(1'b0);
    i_host_model.ack(e, g, r);
    `CHK(e, 16'h0040)
    // Counter 6: simple edges, reset pin, compare output
    i_host_model.wr(7'h07, 16'h4100);
    i_host_model.wr(7'h5c, 16'h0001);
    i_host_model.wr(7'h56, 16'h0018);
    pins.in_a = 1'b1;
    idle();
    `CHK(ch6_val, 25'h0000001)
    `CHK(cnt_out[5], 1'b1)
    i_host_model.ack(e, g, r);
    `CHK(e, 16'h0020)
    `CHK(g, 16'h0000)
    i_host_model.wr(7'h07, 16'h4000);
    pins.rst = 1'b1;
    idle();
    i_host_model.rd(7'h74, d);
    `CHK(d, 16'h0001)
    pins.rst = 1'b0;
    pins.in_a = 1'b0;
    idle();
    `CHK(ch6_val, 25'h0000000)
    pins.in_a = 1'b1;
    i_host_model.wr(7'h56, 16'h0098);
    pins.rst = 1'b1;
    idle();
    `CHK(ch6_val, 25'h0000000)
    // Output enables, random masks
    repeat (4) begin
      v = 16'($urandom) & 16'hfeff;
      i_host_model.wr(7'h07, v);
      cout = 5'($urandom);
      ch7_out = 1'($urandom);
      idle();
      `CHK(cnt_out[4:0], cout & v[13:9])
      `CHK(cnt_out[6], ch7_out & v[15])
    end
    cout = '0;
    ch7_out = 1'b0;
    idle();
    i_host_model.wr(7'h07, 16'h0100);
    // Rising edges of gates and outputs
    for (i = 0; i < 10; i++) begin
      i_host_model.wr(7'h08, edge_word(i));
      if (i < 5) pins.gate[i] = 1'b1;
      else cout[i - 5] = 1'b1;
      wait_irq(1'b0);
      i_host_model.ack(e, g, r);
      `CHK(g, edge_word(i))
      pins.gate = '0;
      cout = '0;
      idle();
      `CHK(irq, 1'b0)
    end
    // Error group: latched always, signalled only when enabled
    i = $urandom_range(0, 7);
    err_evt[i] = 1'b1;
    @(negedge clk);
    err_evt = '0;
    idle();
    `CHK(err_irq, 1'b0)
    i_host_model.wr(7'h07, 16'h0001);
    wait_irq(1'b1);
    i_host_model.ack(e, g, r);
    `CHK(r, 16'(1 << i))
    `CHK(err_irq, 1'b0)
    // Error pulse while the error group is already enabled
    err_evt[i] = 1'b1;
    @(negedge clk);
    err_evt = '0;
    wait_irq(1'b1);
    i_host_model.ack(e, g, r);
    `CHK(r, 16'(1 << i))
    `CHK(err_irq, 1'b0)
    test_done();
  end
endmodule : counter_compare_interrupt_bench
